/* File: cpc_analog_model.sv */
// behavioural model of the analog section behind the power control bank
// assumes the power word arrives as stored, on the same clock as the bank
module cpc_analog_model
  import cpc_pkg::*;
#(
  parameter int SETTLE = 4
)
(
  input wire logic clock_i, // system clock
  input wire logic reset_i, // synchronous, active high
  input wire cpc_pkg::cpc_pwr_t pwr_i, // power control word
  output cpc_pkg::cpc_done_t done_o // power-down completion flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // completion lags the request, as a real block winds down over time
  // --------------------------------------------------------------------------
  cpc_done_t pipe [SETTLE];

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < SETTLE; i++) pipe[i] <= 4'hf;
    end
    else
    begin
      pipe[0] <= {pwr_i.adc_off, pwr_i.dac_off, pwr_i.dac_off, pwr_i.sidetone_off};
      for (int i = 1; i < SETTLE; i++) pipe[i] <= pipe[i-1];
    end
  end

  assign done_o = pipe[SETTLE-1];
endmodule : cpc_analog_model

/* File: cpc_params.svh */
// register offsets, field positions, reset values and gain limits of the
// codec power control bank; assumes a word-wide decoded serial control port
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define CPC_ADDR_W 6
`define CPC_ADDR_AUDIO_CTRL2 6'h04
`define CPC_ADDR_PWR_CTRL 6'h05

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CPC_BIT_STEP_RATE 1
`define CPC_BIT_GAIN_FLAG 0
`define CPC_PD_HI 15
`define CPC_PD_LO 6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CPC_PWR_RESET 16'hfffc
`define CPC_AC2_RESET 16'h0000
`define CPC_PD_ALL 10'h3ff

// ----------------------------------------------------------------------------
// gain codes, 0.5 db per code
// ----------------------------------------------------------------------------
`define CPC_DAC_GAIN_W 7
`define CPC_PGA_AGC_FLOOR 8'he8
`define CPC_PGA_MAX 8'h77

`endif

/* File: cpc_pkg.sv */
// types shared by the codec power control bank
// assumes cpc_params.svh is on the include path
package cpc_pkg;

  // --------------------------------------------------------------------------
  // power control word, msb first as it sits in the register
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic handset_mic_bias_off;
    logic headset_mic_bias_off;
    logic sidetone_off;
    logic speaker_one_off;
    logic speaker_two_off;
    logic dac_off;
    logic adc_off;
    logic virtual_ground_off;
    logic phone_output_off;
    logic loudspeaker_off;
    logic adc_off_done;
    logic dac_left_off_done;
    logic dac_right_off_done;
    logic sidetone_off_done;
    logic effects_filter_on;
    logic deemphasis_on;
  } cpc_pwr_t;

  // completion flags reported by the analog section
  typedef struct packed {
    logic adc_off_done;
    logic dac_left_off_done;
    logic dac_right_off_done;
    logic sidetone_off_done;
  } cpc_done_t;

  // gain state of the input amplifier, 0.5 db per code, signed
  typedef struct packed {
    logic agc_enable;
    logic signed [7:0] applied;
    logic signed [7:0] target;
  } cpc_pga_t;

endpackage : cpc_pkg

/* File: cpc_power_regs.sv */
// codec power control and audio control 2 (bits 1..0) register bank
// assumes register accesses arrive as decoded words from the serial control
// port, and a one-cycle word clock tick synchronous to clock_i
`include "cpc_params.svh"

// ----------------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------------
// Operation
// - dac gain moves 0.5 db per word clock, or per two when rate bit set
// - without agc, gain flag is 1 once applied input gain equals setting
// - with agc, gain flag is 1 when gain sits at -12 db or maximum
// - bits 15,14 power down handset and headset mic bias; reset to 1
// - bit 13 powers down analog sidetone when 1; resets to 1
// - bits 12,11 power down speaker outputs one and two; reset to 1
// - bits 10,9 power down dac and adc when 1; reset to 1
// - bit 8 powers down driver virtual ground when 1; resets to 1
// - bits 7,6 power down phone output and loudspeaker; reset to 1
// - read-only bit 5 shows adc power-down complete; resets to 1
// - read-only bits 4,3 show left and right dac power-down complete
// - read-only bit 2 shows sidetone power-down complete; resets to 1
// - bit 1 enables the effects filter; resets to 0
// - bit 0 enables the de-emphasis filter; resets to 0
// - with bits 15 to 6 all set, whole codec section is powered down
module cpc_power_regs (
  input wire logic clock_i, // 125 mhz system clock
  input wire logic reset_i, // synchronous, active high
  input wire logic enable_i, // clock enable, freezes all state when low
  input wire logic [`CPC_ADDR_W-1:0] reg_addr_i, // register address
  input wire logic reg_wr_i, // write strobe, one cycle
  input wire logic [15:0] reg_wdata_i, // write data
  input wire logic reg_rd_i, // read strobe, one cycle
  output logic [15:0] reg_rdata_o, // read data, registered
  output logic reg_rvalid_o, // read data valid, one cycle
  input wire logic word_tick_i, // one pulse per audio word clock
  input wire logic [`CPC_DAC_GAIN_W-1:0] dac_left_target_i, // programmed left gain
  input wire logic [`CPC_DAC_GAIN_W-1:0] dac_right_target_i, // programmed right gain
  output logic [`CPC_DAC_GAIN_W-1:0] dac_left_gain_o, // applied left gain
  output logic [`CPC_DAC_GAIN_W-1:0] dac_right_gain_o, // applied right gain
  input wire cpc_pkg::cpc_pga_t pga_i, // input amplifier gain state
  input wire cpc_pkg::cpc_done_t done_i, // power-down completion from analog
  output cpc_pkg::cpc_pwr_t pwr_o, // power control word as stored
  output logic dac_gain_step_rate_o, // soft-step rate bit
  output logic codec_all_off_o // whole codec section powered down
);
  import cpc_pkg::*;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // one code toward the target, used for both dac channels
  function automatic logic [`CPC_DAC_GAIN_W-1:0] step_toward(
    input logic [`CPC_DAC_GAIN_W-1:0] cur,
    input logic [`CPC_DAC_GAIN_W-1:0] tgt
  );
    logic [`CPC_DAC_GAIN_W-1:0] res;
    res = cur;
    if (cur < tgt)
    begin
      res = cur + `CPC_DAC_GAIN_W'(1);
    end
    else if (cur > tgt)
    begin
      res = cur - `CPC_DAC_GAIN_W'(1);
    end
    return res;
  endfunction : step_toward

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  cpc_pwr_t pwr;
  logic step_rate;
  logic gain_flag;
  logic next_gain_flag;
  logic half_tick;
  logic step_now;
  logic [15:0] next_rdata;
  logic wr_pwr;
  logic wr_ac2;

  assign wr_pwr = enable_i && reg_wr_i && (reg_addr_i == `CPC_ADDR_PWR_CTRL);
  assign wr_ac2 = enable_i && reg_wr_i && (reg_addr_i == `CPC_ADDR_AUDIO_CTRL2);

  // --------------------------------------------------------------------------
  // writable power-down and filter bits
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pwr.handset_mic_bias_off <= 1'b1;
      pwr.headset_mic_bias_off <= 1'b1;
      pwr.sidetone_off <= 1'b1;
      pwr.speaker_one_off <= 1'b1;
      pwr.speaker_two_off <= 1'b1;
      pwr.dac_off <= 1'b1;
      pwr.adc_off <= 1'b1;
      pwr.virtual_ground_off <= 1'b1;
      pwr.phone_output_off <= 1'b1;
      pwr.loudspeaker_off <= 1'b1;
      pwr.effects_filter_on <= 1'b0;
      pwr.deemphasis_on <= 1'b0;
      pwr.adc_off_done <= 1'b1;
      pwr.dac_left_off_done <= 1'b1;
      pwr.dac_right_off_done <= 1'b1;
      pwr.sidetone_off_done <= 1'b1;
    end
    else if (enable_i)
    begin
      // completion flags follow the analog section; one process keeps one driver
      pwr.adc_off_done <= done_i.adc_off_done;
      pwr.dac_left_off_done <= done_i.dac_left_off_done;
      pwr.dac_right_off_done <= done_i.dac_right_off_done;
      pwr.sidetone_off_done <= done_i.sidetone_off_done;
      if (wr_pwr)
      begin
        // the completion flag lanes of the write word are dropped here
        pwr.handset_mic_bias_off <= reg_wdata_i[15];
        pwr.headset_mic_bias_off <= reg_wdata_i[14];
        pwr.sidetone_off <= reg_wdata_i[13];
        pwr.speaker_one_off <= reg_wdata_i[12];
        pwr.speaker_two_off <= reg_wdata_i[11];
        pwr.dac_off <= reg_wdata_i[10];
        pwr.adc_off <= reg_wdata_i[9];
        pwr.virtual_ground_off <= reg_wdata_i[8];
        pwr.phone_output_off <= reg_wdata_i[7];
        pwr.loudspeaker_off <= reg_wdata_i[6];
        pwr.effects_filter_on <= reg_wdata_i[1];
        pwr.deemphasis_on <= reg_wdata_i[0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // audio control 2 low bits
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      step_rate <= 1'b0;
    end
    else if (wr_ac2)
    begin
      step_rate <= reg_wdata_i[`CPC_BIT_STEP_RATE];
    end
  end

  // flag is registered on every enabled clock, so a read returns the gain state of one cycle earlier
  always_comb
  begin
    if (pga_i.agc_enable)
    begin
      next_gain_flag = (pga_i.applied == `CPC_PGA_AGC_FLOOR) ||
                       (pga_i.applied == `CPC_PGA_MAX);
    end
    else
    begin
      next_gain_flag = (pga_i.applied == pga_i.target);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      gain_flag <= 1'b0;
    end
    else if (enable_i)
    begin
      gain_flag <= next_gain_flag;
    end
  end

  // --------------------------------------------------------------------------
  // dac gain soft-stepping
  // --------------------------------------------------------------------------
  // the half-rate phase restarts with the rate bit, so a slow step never
  // lands on the first tick after switching
  assign step_now = enable_i && word_tick_i && (!step_rate || half_tick);

  always_ff @(posedge clock_i)
  begin
    if (reset_i || wr_ac2)
    begin
      half_tick <= 1'b0;
    end
    else if (enable_i && word_tick_i)
    begin
      half_tick <= !half_tick;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      dac_left_gain_o <= '0;
      dac_right_gain_o <= '0;
    end
    else if (step_now)
    begin
      dac_left_gain_o <= step_toward(dac_left_gain_o, dac_left_target_i);
      dac_right_gain_o <= step_toward(dac_right_gain_o, dac_right_target_i);
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_addr_i == `CPC_ADDR_PWR_CTRL)
    begin
      next_rdata = pwr;
    end
    else if (reg_addr_i == `CPC_ADDR_AUDIO_CTRL2)
    begin
      next_rdata[`CPC_BIT_STEP_RATE] = step_rate;
      next_rdata[`CPC_BIT_GAIN_FLAG] = gain_flag;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end
    else if (enable_i)
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  assign pwr_o = pwr;
  assign dac_gain_step_rate_o = step_rate;
  assign codec_all_off_o = (pwr[`CPC_PD_HI:`CPC_PD_LO] == `CPC_PD_ALL);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_fast_tick;
    enable_i && word_tick_i && !step_rate && !wr_ac2 &&
      (dac_left_gain_o < dac_left_target_i);
  endsequence

  sequence s_slow_pair;
    enable_i && word_tick_i && step_rate && !half_tick && !wr_ac2;
  endsequence

  sequence s_slow_go;
    enable_i && word_tick_i && step_rate && half_tick && !wr_ac2 &&
      (dac_left_gain_o > dac_left_target_i);
  endsequence

  chk_fast_step_up: assert property (
    s_fast_tick |=> dac_left_gain_o == $past(dac_left_gain_o) + `CPC_DAC_GAIN_W'(1))
    else $error("dac gain did not step on word tick");

  chk_slow_step_hold: assert property (
    s_slow_pair |=> dac_left_gain_o == $past(dac_left_gain_o))
    else $error("dac gain stepped on odd tick at slow rate");

  chk_no_idle_step: assert property (
    !(enable_i && word_tick_i) |=> $stable(dac_right_gain_o))
    else $error("dac gain moved without a word tick");

  chk_flag_settle: assert property (
    enable_i && !pga_i.agc_enable && pga_i.applied != pga_i.target |=> !gain_flag)
    else $error("gain flag set while gain still stepping");

  chk_flag_agc_sat: assert property (
    enable_i && pga_i.agc_enable && pga_i.applied == `CPC_PGA_AGC_FLOOR |=> gain_flag)
    else $error("agc saturation not flagged");

  chk_all_off_out: assert property (
    codec_all_off_o == (pwr_o.handset_mic_bias_off && pwr_o.loudspeaker_off &&
      pwr_o.headset_mic_bias_off && pwr_o.sidetone_off && pwr_o.dac_off &&
      pwr_o.speaker_one_off && pwr_o.speaker_two_off && pwr_o.adc_off &&
      pwr_o.virtual_ground_off && pwr_o.phone_output_off))
    else $error("full power-down output wrong");

  chk_done_follow: assert property (
    enable_i |=> pwr_o.adc_off_done == $past(done_i.adc_off_done))
    else $error("completion flag does not follow analog state");

  chk_filter_write: assert property (
    wr_pwr |=> pwr_o.effects_filter_on == $past(reg_wdata_i[1]) ##1
      $stable(pwr_o.effects_filter_on) || $past(wr_pwr))
    else $error("effects filter bit not written");

  chk_read_power: assert property (
    enable_i && reg_rd_i && reg_addr_i == `CPC_ADDR_PWR_CTRL
      |=> reg_rvalid_o && reg_rdata_o[15] == $past(pwr_o.handset_mic_bias_off))
    else $error("power control read wrong");

  chk_reset_word: assert property (
    disable iff (1'b0) $fell(reset_i) |-> pwr_o == `CPC_PWR_RESET)
    else $error("power control reset value wrong");

  chk_slow_step_down: assert property (
    s_slow_go |=> dac_left_gain_o == $past(dac_left_gain_o) - `CPC_DAC_GAIN_W'(1))
    else $error("dac gain did not step on even tick at slow rate");

  chk_rate_write: assert property (
    wr_ac2 |=> dac_gain_step_rate_o == $past(reg_wdata_i[`CPC_BIT_STEP_RATE]))
    else $error("step rate bit not written");

  chk_flag_match: assert property (
    enable_i && !pga_i.agc_enable && pga_i.applied == pga_i.target |=> gain_flag)
    else $error("gain flag clear although gain settled");

  chk_flag_agc_max: assert property (
    enable_i && pga_i.agc_enable && pga_i.applied == `CPC_PGA_MAX |=> gain_flag)
    else $error("agc maximum not flagged");

  chk_flag_agc_clear: assert property (
    enable_i && pga_i.agc_enable && pga_i.applied != `CPC_PGA_AGC_FLOOR &&
      pga_i.applied != `CPC_PGA_MAX |=> !gain_flag)
    else $error("agc saturation flagged while not saturated");

  chk_bias_write: assert property (
    wr_pwr |=> pwr_o[15:14] == $past(reg_wdata_i[15:14]))
    else $error("mic bias bits not written");

  chk_power_write: assert property (
    wr_pwr |=> pwr_o[13:6] == $past(reg_wdata_i[13:6]))
    else $error("power-down bits not written");

  chk_deemph_write: assert property (
    wr_pwr |=> pwr_o.deemphasis_on == $past(reg_wdata_i[0]))
    else $error("de-emphasis bit not written");

  chk_flag_lanes: assert property (
    wr_pwr |=> pwr_o[5:2] == $past(done_i))
    else $error("host write reached completion flags");

endmodule : cpc_power_regs

/* File: cpc_power_regs_test.sv */
// self-checking bench for the codec power control bank
// assumes cpc_params.svh on the include path and the analog model beside it
`include "cpc_params.svh"
module cpc_power_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cpc_pkg::*;

  logic clock_i = 0, reset_i = 1, enable_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic word_tick_i = 0, reg_rvalid_o, dac_gain_step_rate_o, codec_all_off_o;
  logic [5:0] reg_addr_i = 6'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, rd;
  logic [6:0] tl = 7'h00, tr = 7'h00, gl = 7'h00, gr = 7'h00, lgo, rgo;
  cpc_pga_t pga_i = '0;
  cpc_done_t done_i;
  cpc_pwr_t pwr_o;
  logic [31:0] seed = 32'h0a38597d;
  logic [15:0] wd;
  logic [7:0] ap;
  int err_count = 0, checks = 0, n;
  logic rate;

  cpc_power_regs cpc_power_regs_i (.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .word_tick_i(word_tick_i), .dac_left_target_i(tl), .dac_right_target_i(tr),
    .dac_left_gain_o(lgo), .dac_right_gain_o(rgo), .pga_i(pga_i), .done_i(done_i),
    .pwr_o(pwr_o), .dac_gain_step_rate_o(dac_gain_step_rate_o),
    .codec_all_off_o(codec_all_off_o));
  cpc_analog_model cpc_analog_model_i (.clock_i(clock_i), .reset_i(reset_i), .pwr_i(pwr_o),
    .done_o(done_i));

  initial forever #4 clock_i = ~clock_i;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [6:0] stepf(logic [6:0] c, logic [6:0] t, int k);
    repeat (k) if (c < t) c++; else if (c > t) c--;
    return c;
  endfunction : stepf

  function automatic logic flagf(cpc_pga_t p);
    if (p.agc_enable) return p.applied == `CPC_PGA_AGC_FLOOR || p.applied == `CPC_PGA_MAX;
    return p.applied == p.target;
  endfunction : flagf

  // inputs always move 1 ns after the edge so sampling never races
  task automatic cyc(int k = 1);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(logic [5:0] a, logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    cyc();
    reg_wr_i = 0;
  endtask : wr

  task automatic rdr(logic [5:0] a, output logic [15:0] d);
    reg_addr_i = a;
    reg_rd_i = 1;
    cyc();
    reg_rd_i = 0;
    chk(reg_rvalid_o, 1'b1);
    d = reg_rdata_o;
  endtask : rdr

  task automatic final_report();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial
  begin
    #400000;
    err_count++;
    final_report();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    cyc(16);
    reset_i = 0;
    chk(pwr_o, 16'hfffc);
    chk(codec_all_off_o, 1'b1);
    rdr(6'h05, rd);
    chk(rd, 16'hfffc);
    $display("reset test done");
    for (int i = 0; i < 24; i++)
    begin
      wd = 16'(xs());
      if (i < 2) wd[15:6] = i ? 10'h3ff : 10'h3fe;
      wr(6'h05, wd);
      chk(codec_all_off_o, &wd[15:6]);
      cyc(8);
      rdr(6'h05, rd);
      chk(rd, {wd[15:6], wd[9], wd[10], wd[10], wd[13], wd[1:0]});
      chk(pwr_o[15:6], wd[15:6]);
    end
    enable_i = 0;
    wr(6'h05, ~wd);
    enable_i = 1;
    chk(pwr_o[15:6], wd[15:6]);
    rdr(6'h2a, rd);
    chk(rd, 16'h0000);
    $display("power word test done");
    for (int i = 0; i < 12; i++)
    begin
      ap = (i % 3 == 0) ? 8'he8 : (i % 3 == 1) ? 8'h77 : 8'he9 + 8'(xs() % 32'h8e);
      pga_i = '{i[0], ap, (i % 4 < 2) ? ap : ap + 8'h01};
      cyc(2);
      rdr(6'h04, rd);
      chk(rd[0], flagf(pga_i));
    end
    $display("gain flag test done");
    for (int i = 0; i < 10; i++)
    begin
      rate = i[0];
      wr(6'h04, {14'h0, rate, 1'b1});
      chk(dac_gain_step_rate_o, rate);
      rdr(6'h04, rd);
      chk(rd, {14'h0, rate, flagf(pga_i)});
      tl = gl ^ 7'(xs() & 32'h7);
      tr = gr ^ 7'(xs() & 32'h7);
      n = 1 + int'(xs() % 32'h6);
      repeat (n)
      begin
        word_tick_i = 1;
        cyc();
        word_tick_i = 0;
        cyc(2);
      end
      gl = stepf(gl, tl, rate ? n / 2 : n);
      gr = stepf(gr, tr, rate ? n / 2 : n);
      chk(lgo, gl);
      chk(rgo, gr);
    end
    $display("gain step test done");
    final_report();
  end
endmodule : cpc_power_regs_test
